// ===== pkg/timer16_regs.vh
// constants for the 16-bit counter with input capture
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH

// byte locations on the cpu access port
`define LOC_COUNT_LOWER 2'h0
`define LOC_COUNT_UPPER 2'h1
`define LOC_CAPTURE_LOWER 2'h2
`define LOC_CAPTURE_UPPER 2'h3

// clock source select encodings
`define CS_STOPPED 3'h0
`define CS_SYSCLK 3'h1
`define CS_PRESCALE_A 3'h2
`define CS_PRESCALE_B 3'h3
`define CS_PRESCALE_C 3'h4
`define CS_PRESCALE_D 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

// waveform mode encodings with special meaning here
`define WM_NORMAL 4'h0
`define WM_PC8 4'h1
`define WM_PC9 4'h2
`define WM_PC10 4'h3
`define WM_CTC_OCR 4'h4
`define WM_FAST8 4'h5
`define WM_FAST9 4'h6
`define WM_FAST10 4'h7
`define WM_PFC_ICR 4'h8
`define WM_PFC_OCR 4'h9
`define WM_PC_ICR 4'ha
`define WM_PC_OCR 4'hb
`define WM_CTC_ICR 4'hc
`define WM_FAST_ICR 4'he
`define WM_FAST_OCR 4'hf

// counter values
`define COUNT_BOTTOM 16'h0000
`define COUNT_MAX 16'hffff
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define COUNT_ONE 16'h0001

// reset values
`define CAPTURE_RESET 16'h0000
`define LATCH_RESET 8'h00
`define RDATA_RESET 8'h00
`define SYNC_RESET 3'h0
`define FILTER_HIST_RESET 3'h0

// noise filter depth in samples
`define FILTER_SAMPLES 4
`define FILTER_ALL_ONE 4'hf
`define FILTER_ALL_ZERO 4'h0

`endif

// ===== hdl/timer16_counter_input_capture.v
// 16-bit up/down counter with input capture and shared upper-byte latch
// Notes on behaviour
// RL1: 16-bit counter cleared, incremented or decremented per tick; max and zero flagged.
// RL2: count seen as two byte locations; upper location reaches the shared latch.
// RL3: lower read loads latch with counter upper; lower write loads counter from latch.
// RL4: lower write moves latched upper and written lower byte in one cycle.
// RL5: software writes upper byte first, reads lower byte first.
// RL6: latch keeps its value after a transfer, reusable for several writes.
// RL7: main-line code masks interrupts around two-byte accesses when sharing the latch.
// RL8: clock source zero stops the counter; other codes pick a tick source.
// RL9: counter accessible without ticks; cpu write beats clear or count.
// RL10: overflow flag set at mode-defined point and usable as interrupt request.
// RL11: qualifying edge on chosen trigger copies whole count into capture value.
// RL12: capture flag set with the copy; interrupt when its enable is one.
// RL13: capture flag clears on interrupt service or write of one.
// RL14: capture lower read loads latch; upper location returns latch.
// RL15: capture value writable only in modes using it as top value.
// RL16: trigger from capture pin, or comparator output when select bit set.
// RL17: switching trigger source may capture; software then clears the flag.
// RL18: filter and edge detector disabled in modes using capture value as top.
// RL19: pin observed even when driven by its own port output.
// RL20: filter output changes only after four equal consecutive samples.
// RL21: filter enabled by its bit, runs on system clock, adds four cycles.
// RL22: new capture overwrites capture value; no overrun protection.
// RL23: duty measurement: software flips edge after read, then clears flag.
// RL24: edge select bit chooses rising or falling trigger transition.
`timescale 1ns/100ps
`default_nettype none
`include "timer16_regs.vh"

module timer16_counter_input_capture (
	input wire clk,
	input wire arst_n,
	input wire [1:0] ioAddr,
	input wire ioRead,
	input wire ioWrite,
	input wire [7:0] ioWdata,
	output reg [7:0] ioRdata,
	input wire [2:0] clockSourceSelect,
	input wire [3:0] waveformModeSelect,
	input wire [3:0] prescaleTicks,
	input wire externalClockPin,
	input wire capturePinLevel,
	input wire comparatorOutput,
	input wire comparatorCaptureSelect,
	input wire captureFilterEnable,
	input wire captureEdgeRising,
	input wire captureIrqEnable,
	input wire captureIrqAck,
	input wire captureFlagClear,
	input wire overflowIrqEnable,
	input wire overflowIrqAck,
	input wire overflowFlagClear,
	output reg [15:0] timerCount,
	output reg [15:0] captureValue,
	output reg captureFlag,
	output reg overflowFlag,
	output wire captureIrq,
	output wire overflowIrq,
	output wire countAtMax,
	output wire countAtBottom,
	output wire timerTick
);

	// modes that take the capture value as top
	function icrTopMode;
		input [3:0] mode;
		begin
			icrTopMode = (mode == `WM_PFC_ICR) || (mode == `WM_PC_ICR) ||
				(mode == `WM_CTC_ICR) || (mode == `WM_FAST_ICR);
		end
	endfunction

	// modes that count up and down
	function dualSlopeMode;
		input [3:0] mode;
		begin
			dualSlopeMode = (mode == `WM_PC8) || (mode == `WM_PC9) || (mode == `WM_PC10) ||
				(mode == `WM_PFC_ICR) || (mode == `WM_PFC_OCR) ||
				(mode == `WM_PC_ICR) || (mode == `WM_PC_OCR);
		end
	endfunction

	// modes that restart from zero after top
	function singleSlopeTopMode;
		input [3:0] mode;
		begin
			singleSlopeTopMode = (mode == `WM_FAST8) || (mode == `WM_FAST9) ||
				(mode == `WM_FAST10) || (mode == `WM_FAST_ICR) || (mode == `WM_FAST_OCR);
		end
	endfunction

	function ctcMode;
		input [3:0] mode;
		begin
			ctcMode = (mode == `WM_CTC_OCR) || (mode == `WM_CTC_ICR);
		end
	endfunction

	// transition in the chosen direction between two samples
	function edgeSeen;
		input prev;
		input cur;
		input rising;
		begin
			edgeSeen = rising ? (cur & ~prev) : (~cur & prev);
		end
	endfunction

	// a synchronised level is taken once the last two stages agree
	function stagesAgree;
		input [2:0] stages;
		begin
			stagesAgree = (stages[1] == stages[2]);
		end
	endfunction

	// three-stage synchroniser outputs, change once stages two and three agree
	reg [2:0] extSync;
	reg [2:0] pinSync;
	reg [2:0] compSync;
	reg extLevel;
	reg pinLevel;
	reg compLevel;
	reg extLevelPrev;

	reg [7:0] upperLatch;
	reg countingDown;
	reg [2:0] filterShift;
	reg filterLevel;
	reg triggerPrev;

	reg [15:0] topValue;
	reg next_countingDown;
	reg [15:0] next_timerCount;
	reg tickSel;
	reg overflowEvent;

	wire icrTop = icrTopMode(waveformModeSelect);
	wire triggerRaw = comparatorCaptureSelect ? compLevel : pinLevel; // [RL16]
	wire [3:0] filterWindow = {filterShift, triggerRaw}; // [RL20]
	wire triggerLevel = captureFilterEnable ? filterLevel : triggerRaw; // [RL21]
	wire edgeMatch = edgeSeen(triggerPrev, triggerLevel, captureEdgeRising); // [RL24]
	wire captureEvent = edgeMatch & ~icrTop; // [RL18]

	wire writeCountLower = ioWrite && (ioAddr == `LOC_COUNT_LOWER);
	wire writeCaptureLower = ioWrite && (ioAddr == `LOC_CAPTURE_LOWER) && icrTop; // [RL15]
	wire writeUpper = ioWrite &&
		((ioAddr == `LOC_COUNT_UPPER) || (ioAddr == `LOC_CAPTURE_UPPER));
	wire readCountLower = ioRead && (ioAddr == `LOC_COUNT_LOWER);
	wire readCaptureLower = ioRead && (ioAddr == `LOC_CAPTURE_LOWER);

	assign countAtMax = (timerCount == `COUNT_MAX); // [RL1]
	assign countAtBottom = (timerCount == `COUNT_BOTTOM); // [RL1]
	assign captureIrq = captureFlag & captureIrqEnable; // [RL12]
	assign overflowIrq = overflowFlag & overflowIrqEnable; // [RL10]
	assign timerTick = tickSel;

	// synchronisers; the pin is read back whoever drives it
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			extSync <= `SYNC_RESET;
			pinSync <= `SYNC_RESET;
			compSync <= `SYNC_RESET;
			extLevel <= 1'b0;
			pinLevel <= 1'b0;
			compLevel <= 1'b0;
			extLevelPrev <= 1'b0;
		end else begin
			extSync <= {extSync[1:0], externalClockPin};
			pinSync <= {pinSync[1:0], capturePinLevel}; // [RL19]
			compSync <= {compSync[1:0], comparatorOutput};
			if (stagesAgree(extSync)) begin
				extLevel <= extSync[2];
			end
			if (stagesAgree(pinSync)) begin
				pinLevel <= pinSync[2];
			end
			if (stagesAgree(compSync)) begin
				compLevel <= compSync[2];
			end
			extLevelPrev <= extLevel;
		end
	end

	// tick source selection
	always @* begin
		case (clockSourceSelect)
			`CS_STOPPED: tickSel = 1'b0; // [RL8]
			`CS_SYSCLK: tickSel = 1'b1;
			`CS_PRESCALE_A: tickSel = prescaleTicks[0];
			`CS_PRESCALE_B: tickSel = prescaleTicks[1];
			`CS_PRESCALE_C: tickSel = prescaleTicks[2];
			`CS_PRESCALE_D: tickSel = prescaleTicks[3];
			`CS_EXT_FALL: tickSel = edgeSeen(extLevelPrev, extLevel, 1'b0);
			`CS_EXT_RISE: tickSel = edgeSeen(extLevelPrev, extLevel, 1'b1);
			default: tickSel = 1'b0;
		endcase
	end

	// top of the count sequence; compare-register tops fall back to max
	always @* begin
		case (waveformModeSelect)
			`WM_PC8, `WM_FAST8: topValue = `TOP_8BIT;
			`WM_PC9, `WM_FAST9: topValue = `TOP_9BIT;
			`WM_PC10, `WM_FAST10: topValue = `TOP_10BIT;
			`WM_PFC_ICR, `WM_PC_ICR, `WM_CTC_ICR, `WM_FAST_ICR: topValue = captureValue;
			default: topValue = `COUNT_MAX;
		endcase
	end

	// next count and overflow point per mode
	always @* begin
		next_timerCount = timerCount;
		next_countingDown = countingDown;
		overflowEvent = 1'b0;
		if (tickSel) begin
			if (dualSlopeMode(waveformModeSelect)) begin
				if (countingDown) begin
					if (timerCount == `COUNT_BOTTOM) begin
						next_countingDown = 1'b0;
						next_timerCount = timerCount + `COUNT_ONE;
					end else begin
						next_timerCount = timerCount - `COUNT_ONE; // [RL1]
						if (timerCount == `COUNT_ONE) begin
							overflowEvent = 1'b1; // [RL10]
						end
					end
				end else if (timerCount >= topValue) begin
					next_countingDown = 1'b1;
					next_timerCount = timerCount - `COUNT_ONE;
				end else begin
					next_timerCount = timerCount + `COUNT_ONE;
				end
			end else if (singleSlopeTopMode(waveformModeSelect)) begin
				next_countingDown = 1'b0;
				if (timerCount >= topValue) begin
					next_timerCount = `COUNT_BOTTOM; // [RL1]
					overflowEvent = 1'b1; // [RL10]
				end else begin
					next_timerCount = timerCount + `COUNT_ONE;
				end
			end else if (ctcMode(waveformModeSelect) && (timerCount == topValue)) begin
				next_countingDown = 1'b0;
				next_timerCount = `COUNT_BOTTOM;
				overflowEvent = (timerCount == `COUNT_MAX);
			end else begin
				next_countingDown = 1'b0;
				next_timerCount = timerCount + `COUNT_ONE; // [RL1]
				overflowEvent = (timerCount == `COUNT_MAX); // [RL10]
			end
		end
	end

	// counter and direction; cpu write has priority
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timerCount <= `COUNT_BOTTOM;
			countingDown <= 1'b0;
		end else if (writeCountLower) begin
			timerCount <= {upperLatch, ioWdata}; // [RL3] [RL4] [RL9]
		end else begin
			timerCount <= next_timerCount;
			countingDown <= next_countingDown;
		end
	end

	// shared upper-byte latch, never cleared by a transfer
	always @(posedge clk or negedge arst_n) begin // [RL6]
		if (!arst_n) begin
			upperLatch <= `LATCH_RESET;
		end else if (writeUpper) begin
			upperLatch <= ioWdata; // [RL2]
		end else if (readCountLower) begin
			upperLatch <= timerCount[15:8]; // [RL3]
		end else if (readCaptureLower) begin
			upperLatch <= captureValue[15:8]; // [RL14]
		end
	end

	// read data; upper locations return the latch
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ioRdata <= `RDATA_RESET;
		end else if (ioRead) begin
			case (ioAddr)
				`LOC_COUNT_LOWER: ioRdata <= timerCount[7:0];
				`LOC_CAPTURE_LOWER: ioRdata <= captureValue[7:0];
				default: ioRdata <= upperLatch; // [RL2] [RL14]
			endcase
		end
	end

	// noise filter and edge history
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			filterShift <= `FILTER_HIST_RESET;
			filterLevel <= 1'b0;
			triggerPrev <= 1'b0;
		end else begin
			// three held samples plus the current one: four cycles of delay
			filterShift <= {filterShift[1:0], triggerRaw}; // [RL21]
			if (filterWindow == `FILTER_ALL_ONE) begin
				filterLevel <= 1'b1; // [RL20]
			end else if (filterWindow == `FILTER_ALL_ZERO) begin
				filterLevel <= 1'b0; // [RL20]
			end
			triggerPrev <= triggerLevel;
		end
	end

	// capture value, overwritten by every capture
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			captureValue <= `CAPTURE_RESET;
		end else if (writeCaptureLower) begin
			captureValue <= {upperLatch, ioWdata}; // [RL4] [RL15]
		end else if (captureEvent) begin
			captureValue <= timerCount; // [RL11] [RL22]
		end
	end

	// flags: setting wins over clearing
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			captureFlag <= 1'b0;
			overflowFlag <= 1'b0;
		end else begin
			if (captureEvent) begin
				captureFlag <= 1'b1; // [RL12]
			end else if (captureIrqAck || captureFlagClear) begin
				captureFlag <= 1'b0; // [RL13] [RL17]
			end
			if (overflowEvent && !writeCountLower) begin
				overflowFlag <= 1'b1; // [RL10]
			end else if (overflowIrqAck || overflowFlagClear) begin
				overflowFlag <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ===== bench/timer16_asserts.sv
// port-level assertions for the 16-bit counter with input capture
`timescale 1ns/100ps
`default_nettype none
module timer16_asserts (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [1:0] ioAddr,
	input wire logic ioRead,
	input wire logic ioWrite,
	input wire logic [7:0] ioWdata,
	input wire logic [7:0] ioRdata,
	input wire logic [2:0] clockSourceSelect,
	input wire logic [3:0] waveformModeSelect,
	input wire logic captureIrqEnable,
	input wire logic [15:0] timerCount,
	input wire logic [15:0] captureValue,
	input wire logic captureFlag,
	input wire logic captureIrq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire icrTop = waveformModeSelect[3] & ~waveformModeSelect[0];
	sequence s_wr16;
		ioWrite && ioAddr == 2'h1 ##1 ioWrite && ioAddr == 2'h0;
	endsequence
	sequence s_rdCnt;
		ioRead && ioAddr == 2'h0 ##1 ioRead && ioAddr == 2'h1;
	endsequence
	sequence s_rdCap;
		ioRead && ioAddr == 2'h2 ##1 ioRead && ioAddr == 2'h3;
	endsequence
	property p_wr16;
		s_wr16 |=> timerCount == {$past(ioWdata, 2), $past(ioWdata)};
	endproperty
	a_wr16: assert property (p_wr16) else $error("count write lost");
	property p_rdCnt;
		s_rdCnt |=> ioRdata == $past(timerCount[15:8], 2);
	endproperty
	a_rdCnt: assert property (p_rdCnt) else $error("count upper read bad");
	property p_rdLo;
		ioRead && ioAddr == 2'h0 |=> ioRdata == $past(timerCount[7:0]);
	endproperty
	a_rdLo: assert property (p_rdLo) else $error("count lower read bad");
	property p_rdCap;
		s_rdCap |=> ioRdata == $past(captureValue[15:8], 2);
	endproperty
	a_rdCap: assert property (p_rdCap) else $error("capture read bad");
	property p_stop;
		clockSourceSelect == 3'h0 && !(ioWrite && ioAddr == 2'h0) |=> $stable(timerCount);
	endproperty
	a_stop: assert property (p_stop) else $error("stopped count moved");
	property p_capVal;
		$rose(captureFlag) |-> captureValue == $past(timerCount);
	endproperty
	a_capVal: assert property (p_capVal) else $error("capture value bad");
	property p_icrTop;
		$past(icrTop) |-> !$rose(captureFlag);
	endproperty
	a_icrTop: assert property (p_icrTop) else $error("capture in top mode");
	property p_irq;
		captureIrq == (captureFlag & captureIrqEnable);
	endproperty
	a_irq: assert property (p_irq) else $error("capture irq bad");
endmodule
bind timer16_counter_input_capture timer16_asserts i_chk (.clk, .arst_n, .ioAddr, .ioRead,
	.ioWrite, .ioWdata, .ioRdata, .clockSourceSelect, .waveformModeSelect, .captureIrqEnable,
	.timerCount, .captureValue, .captureFlag, .captureIrq);
`default_nettype wire

// ===== bench/capture_source.sv
// model of the outside event source on the capture pin
`timescale 1ns/100ps
`default_nettype none
module capture_source (
	input wire logic clk,
	input wire logic fire,
	input wire logic [3:0] width,
	output logic level
);
	logic [3:0] left = 4'h0;
	initial level = 1'b0;
	// high for width cycles after each fire
	always @(posedge clk) begin
		if (fire) begin
			level <= 1'b1;
			left <= width;
		end else if (left != 4'h0) begin
			left <= left - 4'h1;
			if (left == 4'h1)
				level <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== bench/timer16_counter_input_capture_test.sv
// self-checking bench for the 16-bit counter with input capture
`timescale 1ns/100ps
`default_nettype none
module timer16_counter_input_capture_test;
	logic clk = 1'b0, arst_n = 1'b0, ioRead = 1'b0, ioWrite = 1'b0, comp = 1'b0;
	logic compSel = 1'b0, filt = 1'b0, rise = 1'b1, irqEn = 1'b1, fire = 1'b0;
	logic capAck = 1'b0, capClr = 1'b0, ovfClr = 1'b0, pin, captureFlag, overflowFlag, captureIrq;
	logic extPin = 1'b0, overflowIrq, countAtMax, countAtBottom, timerTick;
	logic [1:0] ioAddr = 2'h0;
	logic [2:0] cs = 3'h0;
	logic [3:0] wm = 4'h0, width = 4'h0, pre = 4'h0;
	logic [7:0] ioWdata = 8'h00, ioRdata;
	logic [15:0] timerCount, captureValue, rv, c0, d0;
	int error_cnt = 0, n_compared = 0, i;
	always #12.5 clk = ~clk;
	capture_source i_src (.clk(clk), .fire(fire), .width(width), .level(pin));
	timer16_counter_input_capture i_dut (.clk(clk), .arst_n(arst_n), .ioAddr(ioAddr),
		.ioRead(ioRead), .ioWrite(ioWrite), .ioWdata(ioWdata), .ioRdata(ioRdata),
		.clockSourceSelect(cs), .waveformModeSelect(wm), .prescaleTicks(pre),
		.externalClockPin(extPin), .capturePinLevel(pin), .comparatorOutput(comp),
		.comparatorCaptureSelect(compSel), .captureFilterEnable(filt),
		.captureEdgeRising(rise), .captureIrqEnable(irqEn), .captureIrqAck(capAck),
		.captureFlagClear(capClr), .overflowIrqEnable(irqEn), .overflowIrqAck(1'b0),
		.overflowFlagClear(ovfClr), .timerCount(timerCount), .captureValue(captureValue),
		.captureFlag(captureFlag), .overflowFlag(overflowFlag), .captureIrq(captureIrq),
		.overflowIrq(overflowIrq), .countAtMax(countAtMax), .countAtBottom(countAtBottom),
		.timerTick(timerTick));
	task automatic conclude();
		if (error_cnt == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic wr, input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		ioAddr <= a;
		ioWdata <= d;
		ioWrite <= wr;
		ioRead <= ~wr;
	endtask
	task automatic idle();
		@(posedge clk);
		ioWrite <= 1'b0;
		ioRead <= 1'b0;
		@(negedge clk);
	endtask
	task automatic wr16(input logic [1:0] a, input logic [15:0] v);
		acc(1'b1, a + 2'h1, v[15:8]);
		acc(1'b1, a, v[7:0]);
		idle();
	endtask
	task automatic rd16(input logic [1:0] a, output logic [15:0] v);
		acc(1'b0, a, 8'h00);
		acc(1'b0, a + 2'h1, 8'h00);
		@(negedge clk) v[7:0] = ioRdata;
		idle();
		v[15:8] = ioRdata;
	endtask
	task automatic pulse(input logic [3:0] w);
		@(negedge clk) c0 = timerCount;
		@(posedge clk) fire <= 1'b1;
		width <= w;
		@(posedge clk) fire <= 1'b0;
	endtask
	task automatic waitCap();
		for (i = 0; i < 30 && captureFlag !== 1'b1; i++)
			@(negedge clk);
		if (captureFlag !== 1'b1) begin
			error_cnt++;
			conclude();
		end
	endtask
	task automatic clearCap(input logic viaAck);
		@(posedge clk) {capAck, capClr} <= {viaAck, ~viaAck};
		@(posedge clk) {capAck, capClr} <= 2'b00;
		@(negedge clk) chk(captureFlag, 16'h0);
	endtask
	task automatic tick3();
		@(posedge clk) cs <= 3'h1;
		repeat (3) @(posedge clk);
		cs <= 3'h0;
		@(negedge clk);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk) chk(countAtBottom, 16'h1);
		chk(countAtMax, 16'h0);
		wr16(2'h0, 16'h01ff);
		chk(timerCount, 16'h01ff);
		repeat (5) @(negedge clk);
		chk(timerCount, 16'h01ff);
		acc(1'b1, 2'h0, 8'h56);
		idle();
		chk(timerCount, 16'h0156);
		acc(1'b1, 2'h3, 8'h99);
		rd16(2'h0, rv);
		chk(rv, 16'h0156);
		wr16(2'h0, 16'hfffd);
		acc(1'b1, 2'h0, 8'hff);
		idle();
		chk(countAtMax, 16'h1);
		@(posedge clk) cs <= 3'h1;
		repeat (6) @(negedge clk);
		chk(overflowFlag, 16'h1);
		chk(overflowIrq, 16'h1);
		chk(timerTick, 16'h1);
		@(posedge clk) ovfClr <= 1'b1;
		@(posedge clk) ovfClr <= 1'b0;
		@(negedge clk) chk(overflowFlag, 16'h0);
		wr16(2'h0, 16'h2000);
		chk(timerCount, 16'h2000);
		pulse(4'h8);
		waitCap();
		d0 = captureValue - c0;
		chk(captureIrq, 16'h1);
		repeat (12) @(negedge clk);
		pulse(4'h8);
		repeat (12) @(negedge clk);
		chk(captureValue - c0, d0);
		clearCap(1'b0);
		repeat (12) @(negedge clk);
		@(posedge clk) filt <= 1'b1;
		pulse(4'h8);
		waitCap();
		chk(captureValue - c0, d0 + 16'h4);
		clearCap(1'b1);
		repeat (12) @(negedge clk);
		pulse(4'h2);
		repeat (16) @(negedge clk);
		chk(captureFlag, 16'h0);
		@(posedge clk) rise <= 1'b0;
		pulse(4'h6);
		waitCap();
		clearCap(1'b0);
		@(posedge clk) {compSel, rise} <= 2'b11;
		repeat (12) @(negedge clk);
		clearCap(1'b0);
		@(posedge clk) comp <= 1'b1;
		waitCap();
		clearCap(1'b1);
		@(posedge clk) {cs, wm, compSel} <= {3'h0, 4'hc, 1'b0};
		wr16(2'h2, 16'h0abc);
		chk(captureValue, 16'h0abc);
		acc(1'b1, 2'h1, 8'h77);
		rd16(2'h2, rv);
		chk(rv, 16'h0abc);
		pulse(4'h8);
		repeat (20) @(negedge clk);
		chk(captureFlag, 16'h0);
		@(posedge clk) wm <= 4'h0;
		wr16(2'h2, 16'h1111);
		chk(captureValue, 16'h0abc);
		wr16(2'h0, 16'h0000);
		for (i = 2; i < 6; i++) begin
			@(posedge clk) cs <= 3'(i);
			pre <= 4'h1 << (i - 2);
		end
		@(posedge clk) {cs, pre, extPin} <= {3'h7, 4'h0, 1'b1};
		repeat (8) @(negedge clk);
		@(posedge clk) {cs, extPin} <= {3'h6, 1'b0};
		repeat (8) @(negedge clk);
		chk(timerCount, 16'h0006);
		chk(timerTick, 16'h0);
		@(posedge clk) {cs, wm} <= {3'h0, 4'h1};
		wr16(2'h0, 16'h00fe);
		tick3();
		chk(timerCount, 16'h00fd);
		@(posedge clk) wm <= 4'h5;
		acc(1'b1, 2'h0, 8'hfe);
		idle();
		tick3();
		chk(timerCount, 16'h0001);
		chk(overflowFlag, 16'h1);
		conclude();
	end
endmodule
`default_nettype wire
